// ==== verilog/bfm_pkg.sv ====
// shared constants and types for the bidirectional fifo mailbox and parity block
package bfm_pkg;
  localparam int DATA_W    = 36;
  localparam int BYTE_W    = 9;
  localparam int NUM_BYTES = 4;
  localparam int CNT_W     = 7;
  localparam int OFS_W     = 6;
  localparam int SEL_W     = 2;
  localparam int STAGE_W   = 36;
  localparam int STAGE_D   = 8;

  localparam logic [CNT_W-1:0] FILL_MAX  = 7'h40;
  localparam logic [CNT_W-1:0] FILL_TOP  = 7'h3F;
  localparam logic [CNT_W-1:0] FILL_ZERO = 7'h00;
  localparam logic [CNT_W-1:0] FILL_ONE  = 7'h01;

  // four preset offsets picked by the strap at reset release
  localparam logic [OFS_W-1:0] OFFSET_P0      = 6'h10;
  localparam logic [OFS_W-1:0] OFFSET_P1      = 6'h0C;
  localparam logic [OFS_W-1:0] OFFSET_P2      = 6'h08;
  localparam logic [OFS_W-1:0] OFFSET_P3      = 6'h04;
  localparam logic [OFS_W-1:0] OFFSET_DEFAULT = 6'h08;

  localparam logic [SEL_W-1:0] SEL_P0 = 2'h0;
  localparam logic [SEL_W-1:0] SEL_P1 = 2'h1;
  localparam logic [SEL_W-1:0] SEL_P2 = 2'h2;

  localparam logic [DATA_W-1:0] WORD_RESET = 36'h0_0000_0000;

  typedef logic [DATA_W-1:0] bfm_word_t;

  // one port's control pins, sampled on the port clock edge
  typedef struct packed {
    logic cs_n;
    logic wr;
    logic en;
    logic mb;
    logic pg;
  } bfm_port_ctl_t;
endpackage

// ==== verilog/bfm_top.sv ====
// mailbox, parity, almost-full logic and output staging of the bidirectional fifo
// Notes on behaviour
// (R1) almost-full made in writer clock, two-stage synchronised
// (R2) almost-full low at 64-X words or more
// (R3) one offset loaded at reset from four presets
// (R4) almost-full rises on second clock after read
// (R5) late read edge pushes first sync cycle
// (R6) two 36-bit mail registers, one each way
// (R7) port-A mail write stores A word
// (R8) port-B mail write stores B word
// (R9) mail write lowers flag; writes ignored while low
// (R10) outputs show fifo register or incoming mail
// (R11) port-B mail read raises first mail flag
// (R12) port-A mail read raises second mail flag
// (R13) mail read never changes mail contents
// (R14) four byte parity trees drive error flag low
// (R15) bytes are 9 bits, top bit parity
// (R16) odd/even select chooses failing low count
// (R17) port-A mail read with generation forces flag high
// (R18) port-B mail read with generation forces flag high
// (R19) generate select enables parity on port reads
// (R20) writes keep all 36 bits unchanged
// (R21) generated parity replaces stored top bit
// (R22) fifo parity made before output register load
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module bfm_stage_fifo #(
  parameter int W = 36,
  parameter int D = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_nrst,
  input  wire logic [W-1:0] i_data,
  input  wire logic         i_valid,
  output logic              o_ready,
  output logic [W-1:0]      o_data,
  output logic              o_valid,
  input  wire logic         i_ready
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(D);
  localparam logic [AW-1:0] PTR_LAST = AW'(D - 1);

  logic [W-1:0]  mem_reg [D];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic          push;
  logic          pop;

  assign push = i_valid && (count_reg != CNT_FULL);
  assign pop  = i_ready && (count_reg != '0);
  assign count_next = count_reg + CW'(push) - CW'(pop);

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= i_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + AW'(1);
      end
      count_reg <= count_next;
    end
  end

  // flags kept in flops so the top's ports come from registers
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ready <= 1'b0;
      o_valid <= 1'b0;
    end else begin
      o_ready <= (count_next != CNT_FULL);
      o_valid <= (count_next != '0);
    end
  end

  assign o_data = mem_reg[rd_ptr_reg];
endmodule

////////////////////////////////////////////////////////////////////////////////
module bfm_top (
  input  wire logic                  i_clk,
  input  wire logic                  i_nrst,
  input  wire bfm_pkg::bfm_port_ctl_t i_port_a_ctl,
  input  wire bfm_pkg::bfm_port_ctl_t i_port_b_ctl,
  input  wire bfm_pkg::bfm_word_t    i_port_a_data,
  input  wire bfm_pkg::bfm_word_t    i_port_b_data,
  output bfm_pkg::bfm_word_t         o_port_a_data,
  output logic                       o_port_a_data_oe,
  output bfm_pkg::bfm_word_t         o_port_b_data,
  output logic                       o_port_b_data_oe,
  input  wire logic                  i_odd_even,
  input  wire logic [1:0]            i_offset_sel,
  input  wire logic                  i_fifo1_wr_stb,
  input  wire logic                  i_fifo1_rd_stb,
  input  wire logic                  i_fifo2_wr_stb,
  input  wire logic                  i_fifo2_rd_stb,
  input  wire bfm_pkg::bfm_word_t    i_fifo1_mem_data,
  input  wire logic                  i_fifo1_mem_valid,
  output logic                       o_fifo1_mem_ready,
  input  wire bfm_pkg::bfm_word_t    i_fifo2_mem_data,
  input  wire logic                  i_fifo2_mem_valid,
  output logic                       o_fifo2_mem_ready,
  output logic [5:0]                 o_offset,
  output logic                       o_fifo1_almost_full_n,
  output logic                       o_fifo2_almost_full_n,
  output logic                       o_mail_ab_full_n,
  output logic                       o_mail_ba_full_n,
  output logic                       o_port_a_parity_error_n,
  output logic                       o_port_b_parity_error_n
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic is_wr(input bfm_pkg::bfm_port_ctl_t c);
    return !c.cs_n && c.wr && c.en;
  endfunction

  function automatic logic is_rd(input bfm_pkg::bfm_port_ctl_t c);
    return !c.cs_n && !c.wr && c.en;
  endfunction

  // error when the count of low bits has the selected oddness
  function automatic logic word_err(input bfm_pkg::bfm_word_t w, input logic odd);
    logic e;
    e = 1'b0;
    for (int i = 0; i < bfm_pkg::NUM_BYTES; i++) begin
      e = e | ((^(~w[i*bfm_pkg::BYTE_W +: bfm_pkg::BYTE_W])) == odd); // [R14] [R15] [R16]
    end
    return e;
  endfunction

  // low eight bits feed the tree, result replaces the top bit
  function automatic bfm_pkg::bfm_word_t gen_par(input bfm_pkg::bfm_word_t w,
                                                 input logic odd);
    bfm_pkg::bfm_word_t r;
    r = w;
    for (int i = 0; i < bfm_pkg::NUM_BYTES; i++) begin
      r[i*bfm_pkg::BYTE_W + bfm_pkg::BYTE_W - 1] =
        (^(~w[i*bfm_pkg::BYTE_W +: bfm_pkg::BYTE_W-1])) ^ odd; // [R21]
    end
    return r;
  endfunction

  function automatic logic [bfm_pkg::CNT_W-1:0] fill_next(
    input logic [bfm_pkg::CNT_W-1:0] c, input logic wr, input logic rd);
    logic [bfm_pkg::CNT_W-1:0] n;
    n = c;
    if (wr && !rd && c != bfm_pkg::FILL_MAX) begin
      n = c + bfm_pkg::FILL_ONE;
    end else if (rd && !wr && c != bfm_pkg::FILL_ZERO) begin
      n = c - bfm_pkg::FILL_ONE;
    end
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // offset strap caught on the first edge after reset release
  logic                        ofs_loaded_reg;
  logic [bfm_pkg::OFS_W-1:0]   offset_reg;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ofs_loaded_reg <= 1'b0;
      offset_reg     <= bfm_pkg::OFFSET_DEFAULT;
    end else if (!ofs_loaded_reg) begin
      ofs_loaded_reg <= 1'b1;
      case (i_offset_sel) // [R3]
        bfm_pkg::SEL_P0: offset_reg <= bfm_pkg::OFFSET_P0;
        bfm_pkg::SEL_P1: offset_reg <= bfm_pkg::OFFSET_P1;
        bfm_pkg::SEL_P2: offset_reg <= bfm_pkg::OFFSET_P2;
        default:         offset_reg <= bfm_pkg::OFFSET_P3;
      endcase
    end
  end

  assign o_offset = offset_reg;

  ////////////////////////////////////////////////////////////////////////////
  // fill levels and almost-full flags
  logic [bfm_pkg::CNT_W-1:0] fill1_reg;
  logic [bfm_pkg::CNT_W-1:0] fill2_reg;
  logic [bfm_pkg::CNT_W-1:0] af_limit;
  logic                      room1;
  logic                      room2;
  logic                      af1_sync1_reg;
  logic                      af2_sync1_reg;

  assign af_limit = bfm_pkg::FILL_TOP - {1'b0, offset_reg};
  assign room1 = (fill1_reg <= af_limit); // [R2]
  assign room2 = (fill2_reg <= af_limit); // [R2]

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      fill1_reg <= bfm_pkg::FILL_ZERO;
      fill2_reg <= bfm_pkg::FILL_ZERO;
    end else begin
      fill1_reg <= fill_next(fill1_reg, i_fifo1_wr_stb, i_fifo1_rd_stb);
      fill2_reg <= fill_next(fill2_reg, i_fifo2_wr_stb, i_fifo2_rd_stb);
    end
  end

  // falling is seen at once by the writer; rising needs two stages.
  // ports share one clock here, so every read meets the skew margin.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      af1_sync1_reg         <= 1'b1;
      af2_sync1_reg         <= 1'b1;
      o_fifo1_almost_full_n <= 1'b1;
      o_fifo2_almost_full_n <= 1'b1;
    end else begin
      af1_sync1_reg         <= room1;                  // [R1] [R5]
      af2_sync1_reg         <= room2;                  // [R1] [R5]
      o_fifo1_almost_full_n <= af1_sync1_reg && room1; // [R1] [R4]
      o_fifo2_almost_full_n <= af2_sync1_reg && room2; // [R1] [R4]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mail registers
  logic               a_mail_wr;
  logic               b_mail_wr;
  logic               a_mail_rd;
  logic               b_mail_rd;
  bfm_pkg::bfm_word_t mail_ab_reg;
  bfm_pkg::bfm_word_t mail_ba_reg;

  assign a_mail_wr = is_wr(i_port_a_ctl) && i_port_a_ctl.mb;
  assign b_mail_wr = is_wr(i_port_b_ctl) && i_port_b_ctl.mb;
  assign a_mail_rd = is_rd(i_port_a_ctl) && i_port_a_ctl.mb;
  assign b_mail_rd = is_rd(i_port_b_ctl) && i_port_b_ctl.mb;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mail_ab_reg      <= bfm_pkg::WORD_RESET;
      o_mail_ab_full_n <= 1'b1;
    end else if (a_mail_wr && o_mail_ab_full_n) begin
      mail_ab_reg      <= i_port_a_data; // [R6] [R7] [R20]
      o_mail_ab_full_n <= 1'b0;          // [R9]
    end else if (b_mail_rd) begin
      o_mail_ab_full_n <= 1'b1;          // [R11] [R13]
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mail_ba_reg      <= bfm_pkg::WORD_RESET;
      o_mail_ba_full_n <= 1'b1;
    end else if (b_mail_wr && o_mail_ba_full_n) begin
      mail_ba_reg      <= i_port_b_data; // [R6] [R8] [R20]
      o_mail_ba_full_n <= 1'b0;          // [R9]
    end else if (a_mail_rd) begin
      o_mail_ba_full_n <= 1'b1;          // [R12] [R13]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // staging fifos between memory read and output registers
  bfm_pkg::bfm_word_t stg1_data;
  bfm_pkg::bfm_word_t stg2_data;
  logic               stg1_valid;
  logic               stg2_valid;
  logic               b_fifo_rd;
  logic               a_fifo_rd;

  assign b_fifo_rd = is_rd(i_port_b_ctl) && !i_port_b_ctl.mb;
  assign a_fifo_rd = is_rd(i_port_a_ctl) && !i_port_a_ctl.mb;

  bfm_stage_fifo #(.W(bfm_pkg::STAGE_W), .D(bfm_pkg::STAGE_D)) u_stage1 (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_data  (i_fifo1_mem_data),
    .i_valid (i_fifo1_mem_valid),
    .o_ready (o_fifo1_mem_ready),
    .o_data  (stg1_data),
    .o_valid (stg1_valid),
    .i_ready (b_fifo_rd)
  );

  bfm_stage_fifo #(.W(bfm_pkg::STAGE_W), .D(bfm_pkg::STAGE_D)) u_stage2 (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_data  (i_fifo2_mem_data),
    .i_valid (i_fifo2_mem_valid),
    .o_ready (o_fifo2_mem_ready),
    .o_data  (stg2_data),
    .o_valid (stg2_valid),
    .i_ready (a_fifo_rd)
  );

  // parity made on the word before it lands in the output register
  bfm_pkg::bfm_word_t fifo1_out_reg;
  bfm_pkg::bfm_word_t fifo2_out_reg;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      fifo1_out_reg <= bfm_pkg::WORD_RESET;
      fifo2_out_reg <= bfm_pkg::WORD_RESET;
    end else begin
      if (b_fifo_rd && stg1_valid) begin
        fifo1_out_reg <= i_port_b_ctl.pg ? gen_par(stg1_data, i_odd_even) : stg1_data; // [R22]
      end
      if (a_fifo_rd && stg2_valid) begin
        fifo2_out_reg <= i_port_a_ctl.pg ? gen_par(stg2_data, i_odd_even) : stg2_data; // [R22]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port drivers; stored mail is never overwritten by generated parity
  bfm_pkg::bfm_word_t a_mail_view;
  bfm_pkg::bfm_word_t b_mail_view;

  assign a_mail_view = i_port_a_ctl.pg ? gen_par(mail_ba_reg, i_odd_even) : mail_ba_reg; // [R19]
  assign b_mail_view = i_port_b_ctl.pg ? gen_par(mail_ab_reg, i_odd_even) : mail_ab_reg; // [R19]

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_port_a_data    <= bfm_pkg::WORD_RESET;
      o_port_b_data    <= bfm_pkg::WORD_RESET;
      o_port_a_data_oe <= 1'b0;
      o_port_b_data_oe <= 1'b0;
    end else begin
      o_port_a_data    <= i_port_a_ctl.mb ? a_mail_view : fifo2_out_reg; // [R10]
      o_port_b_data    <= i_port_b_ctl.mb ? b_mail_view : fifo1_out_reg; // [R10]
      o_port_a_data_oe <= !i_port_a_ctl.cs_n && !i_port_a_ctl.wr;
      o_port_b_data_oe <= !i_port_b_ctl.cs_n && !i_port_b_ctl.wr;
    end
  end

  // parity check on the input pins, forced clear during generated mail reads
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_port_a_parity_error_n <= 1'b1;
      o_port_b_parity_error_n <= 1'b1;
    end else begin
      o_port_a_parity_error_n <= (a_mail_rd && i_port_a_ctl.pg) ||
                                 !word_err(i_port_a_data, i_odd_even); // [R14] [R17]
      o_port_b_parity_error_n <= (b_mail_rd && i_port_b_ctl.pg) ||
                                 !word_err(i_port_b_data, i_odd_even); // [R14] [R18]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_room_back;
    !room1 ##1 room1;
  endsequence

  sequence s_af_slow_rise;
    !o_fifo1_almost_full_n ##1 o_fifo1_almost_full_n;
  endsequence

  a_af_rise_delay: assert property (s_room_back ##1 room1 |-> s_af_slow_rise) // [R4]
    else $error("almost-full did not rise on second edge after read");

  a_af_fall_fast: assert property (!room1 |=> !o_fifo1_almost_full_n) // [R2]
    else $error("almost-full missed fill above limit");

  a_af2_level: assert property (room2 [*2] |=> o_fifo2_almost_full_n) // [R1]
    else $error("fifo2 almost-full stuck low with room");

  a_mail_ab_store: assert property (a_mail_wr && o_mail_ab_full_n
      |=> !o_mail_ab_full_n && mail_ab_reg == $past(i_port_a_data)) // [R7]
    else $error("port a mail write not stored");

  a_mail_ab_block: assert property (!o_mail_ab_full_n && !b_mail_rd
      |=> !o_mail_ab_full_n && $stable(mail_ab_reg)) // [R9]
    else $error("mail written while flag low");

  a_mail_ab_free: assert property (b_mail_rd && o_mail_ab_full_n == 1'b0 && !a_mail_wr
      |=> o_mail_ab_full_n) // [R11]
    else $error("port b mail read left flag low");

  a_mail_ba_free: assert property (a_mail_rd && !b_mail_wr |=> o_mail_ba_full_n) // [R12]
    else $error("port a mail read left flag low");

  a_mail_read_keep: assert property (!(a_mail_wr && o_mail_ab_full_n)
      |=> $stable(mail_ab_reg)) // [R13]
    else $error("mail contents changed without a write");

  a_par_forced: assert property (b_mail_rd && i_port_b_ctl.pg
      |=> o_port_b_parity_error_n) // [R18]
    else $error("port b parity flag not forced high");

  a_par_check: assert property (!(a_mail_rd && i_port_a_ctl.pg)
      && word_err(i_port_a_data, i_odd_even) |=> !o_port_a_parity_error_n) // [R14]
    else $error("port a parity error not flagged");

  a_mail_out_sel: assert property (i_port_b_ctl.mb && !i_port_b_ctl.pg
      |=> o_port_b_data == $past(mail_ab_reg)) // [R10]
    else $error("port b not showing mail register");
endmodule

// ==== test/bfm_mem_model.sv ====
// memory-side source model feeding one staging fifo of the block
`timescale 1ns/1ps

module bfm_mem_model #(
  parameter bfm_pkg::bfm_word_t BASE = 36'h1_0000_0000
) (
  input  wire logic          i_clk,
  input  wire logic          i_nrst,
  input  wire logic          i_stall,
  input  wire logic          i_ready,
  output logic               o_valid,
  output bfm_pkg::bfm_word_t o_data
);
  logic [7:0] cnt_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // an offered word stays put until taken, even if a stall arrives meanwhile
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_reg <= 8'h00;
      o_valid <= 1'b0;
    end else if (o_valid && i_ready) begin
      cnt_reg <= cnt_reg + 8'h01;
      o_valid <= !i_stall;
    end else if (!o_valid) begin
      o_valid <= !i_stall;
    end
  end

  // idle bus shows the inverse of the last word so stale data cannot pass
  assign o_data = o_valid ? BASE + 36'(cnt_reg) : ~(BASE + 36'(cnt_reg) - 36'h1);
endmodule

// ==== test/tb_bfm_top.sv ====
// self-checking bench for the fifo mailbox parity block
`timescale 1ns/1ps

module tb_bfm_top;
  typedef struct {
    int                 cyc;
    int                 kind;
    bfm_pkg::bfm_word_t val;
  } bfm_note_t;

  localparam bfm_pkg::bfm_word_t     BASE1 = 36'hA_5000_0000;
  localparam bfm_pkg::bfm_word_t     BASE2 = 36'h3_C000_1000;
  localparam bfm_pkg::bfm_port_ctl_t IDLE  = 5'h10;

  logic                   i_clk, i_nrst, odd_even, oe_a, oe_b, ab_n, ba_n, pe_a_n, pe_b_n;
  logic [1:0]             offset_sel, stall, wr_stb, rd_stb;
  // bits driven by separate output ports or separate instances, so these stay nets
  wire  [1:0]             mem_valid, mem_ready, af_n;
  logic [5:0]             offset;
  logic [9:0]             flags;
  bfm_pkg::bfm_port_ctl_t a_ctl, b_ctl;
  bfm_pkg::bfm_word_t     a_in, b_in, a_out, b_out, mem1, mem2;
  logic [31:0]            seed = 32'h8B5C819E;
  int                     ncyc = 0;
  int                     tcnt = 0;
  int                     fail_count = 0;
  int                     comparisons = 0;
  bfm_note_t              notes[$];

  assign flags = {mem_ready, oe_b, oe_a, af_n, pe_b_n, pe_a_n, ba_n, ab_n};

  bfm_top dut (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_port_a_ctl(a_ctl), .i_port_b_ctl(b_ctl),
    .i_port_a_data(a_in), .i_port_b_data(b_in), .o_port_a_data(a_out),
    .o_port_a_data_oe(oe_a), .o_port_b_data(b_out), .o_port_b_data_oe(oe_b),
    .i_odd_even(odd_even), .i_offset_sel(offset_sel),
    .i_fifo1_wr_stb(wr_stb[0]), .i_fifo1_rd_stb(rd_stb[0]),
    .i_fifo2_wr_stb(wr_stb[1]), .i_fifo2_rd_stb(rd_stb[1]),
    .i_fifo1_mem_data(mem1), .i_fifo1_mem_valid(mem_valid[0]),
    .o_fifo1_mem_ready(mem_ready[0]), .i_fifo2_mem_data(mem2),
    .i_fifo2_mem_valid(mem_valid[1]), .o_fifo2_mem_ready(mem_ready[1]),
    .o_offset(offset), .o_fifo1_almost_full_n(af_n[0]), .o_fifo2_almost_full_n(af_n[1]),
    .o_mail_ab_full_n(ab_n), .o_mail_ba_full_n(ba_n),
    .o_port_a_parity_error_n(pe_a_n), .o_port_b_parity_error_n(pe_b_n)
  );
  bfm_mem_model #(.BASE(BASE1)) mem_1 (.i_clk(i_clk), .i_nrst(i_nrst), .i_stall(stall[0]),
    .i_ready(mem_ready[0]), .o_valid(mem_valid[0]), .o_data(mem1));
  bfm_mem_model #(.BASE(BASE2)) mem_2 (.i_clk(i_clk), .i_nrst(i_nrst), .i_stall(stall[1]),
    .i_ready(mem_ready[1]), .o_valid(mem_valid[1]), .o_data(mem2));

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic bfm_pkg::bfm_word_t rnd();
    logic [31:0] hi;
    hi = xs();
    return {hi[3:0], xs()};
  endfunction
  // a byte fails when its count of low bits has the parity odd_even selects
  function automatic logic err(input bfm_pkg::bfm_word_t w, input logic oe);
    err = 1'b0;
    for (int b = 0; b < 4; b++)
      err = err | ((^(~w[9*b +: 9])) == oe);
  endfunction
  function automatic bfm_pkg::bfm_word_t gen(input bfm_pkg::bfm_word_t w, input logic oe);
    for (int b = 0; b < 4; b++)
      w[9*b+8] = (^(~w[9*b +: 8])) ^ oe;
    return w;
  endfunction
  function automatic bfm_pkg::bfm_port_ctl_t mk(input logic wr, input logic mb, input logic pg);
    return {1'b0, wr, 1'b1, mb, pg};
  endfunction
  function automatic bfm_pkg::bfm_word_t got(input int k);
    if (k == 0) return a_out;
    if (k == 1) return b_out;
    if (k == 12) return 36'(offset);
    return 36'(flags[k-2]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tick();
    @(posedge i_clk);
  endtask
  task automatic note(input int d, input int k, input bfm_pkg::bfm_word_t v);
    notes.push_back('{ncyc + d, k, v});
  endtask
  task automatic drive(input int p, input bfm_pkg::bfm_port_ctl_t c, input bfm_pkg::bfm_word_t w);
    if (p == 0) begin
      a_ctl <= c;
      a_in <= w;
    end else begin
      b_ctl <= c;
      b_in <= w;
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic reset_dut(input logic [1:0] s);
    bfm_pkg::bfm_word_t ofs;
    ofs = 36'(s == 2'h0 ? bfm_pkg::OFFSET_P0 : s == 2'h1 ? bfm_pkg::OFFSET_P1 :
              s == 2'h2 ? bfm_pkg::OFFSET_P2 : bfm_pkg::OFFSET_P3);
    tick();
    i_nrst <= 1'b0;
    offset_sel <= s;
    for (int k = 2; k < 12; k++)
      note(2, k, 36'(k < 8));
    note(2, 12, 36'(bfm_pkg::OFFSET_DEFAULT));
    repeat (2) tick();
    i_nrst <= 1'b1;
    note(2, 12, ofs);
    tick();
    $display("done: reset with offset select %0d", s);
  endtask

  task automatic af(input int f);
    for (int i = 0; i < 64 - int'(bfm_pkg::OFFSET_P3); i++) begin
      tick();
      wr_stb[f] <= 1'b1;
    end
    note(2, 6 + f, 36'h1);
    note(3, 6 + f, 36'h0);
    tick();
    wr_stb[f] <= 1'b0;
    tick();
    rd_stb[f] <= 1'b1;
    note(3, 6 + f, 36'h0);
    note(4, 6 + f, 36'h1);
    tick();
    rd_stb[f] <= 1'b0;
    $display("done: almost full %0d", f);
  endtask

  task automatic mail(input int p);
    bfm_pkg::bfm_word_t w1;
    int q;
    w1 = rnd();
    q = 1 - p;
    tick();
    drive(p, mk(1'b1, 1'b1, 1'b0), w1);
    note(2, 2 + p, 36'h0);
    tick();
    drive(p, mk(1'b1, 1'b1, 1'b0), ~w1);
    note(2, 2 + p, 36'h0);
    tick();
    drive(p, IDLE, 36'h0);
    drive(q, mk(1'b0, 1'b1, 1'b0), 36'h0);
    note(2, q, w1);
    note(2, 2 + p, 36'h1);
    note(2, 8 + q, 36'h1);
    note(2, 4 + q, 36'h0);
    tick();
    drive(q, mk(1'b0, 1'b1, 1'b1), 36'h0);
    note(2, q, gen(w1, 1'b1));
    note(2, 4 + q, 36'h1);
    tick();
    drive(q, mk(1'b0, 1'b1, 1'b0), 36'h0);
    note(2, q, w1);
    tick();
    drive(q, IDLE, 36'h0);
    $display("done: mail from port %0d", p);
  endtask

  task automatic par();
    bfm_pkg::bfm_word_t w;
    logic o;
    for (int i = 0; i < 40; i++) begin
      tick();
      w = rnd();
      o = seed[9];
      if (seed[3])
        w = gen(w, o);
      odd_even <= o;
      drive(0, IDLE, w);
      drive(1, IDLE, ~w);
      note(2, 4, 36'(!err(w, o)));
      note(2, 5, 36'(!err(~w, o)));
    end
    tick();
    odd_even <= 1'b1;
    $display("done: parity check");
  endtask

  // fill staging until it refuses, then drain past empty with pg toggling
  task automatic stream(input int f);
    bfm_pkg::bfm_word_t w;
    int p;
    p = 1 - f;
    tick();
    stall[f] <= 1'b0;
    repeat (12) tick();
    stall[f] <= 1'b1;
    note(1, 10 + f, 36'h0);
    for (int k = 0; k < 10; k++) begin
      tick();
      w = (f == 0 ? BASE1 : BASE2) + 36'(k > 8 ? 8 : k);
      drive(p, mk(1'b0, 1'b0, k[0]), 36'h0);
      note(3, p, (k[0] && k < 9) ? gen(w, 1'b1) : w);
    end
    tick();
    drive(p, IDLE, 36'h0);
    note(2, 10 + f, 36'h1);
    $display("done: fifo stream %0d", f);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge i_clk) begin
    tcnt++;
    if (tcnt == 2000) begin
      fail_count++;
      $display("[FAIL] %0t run did not finish", $time);
      summarize();
    end
  end

  always @(negedge i_clk) begin
    ncyc++;
    for (int i = notes.size() - 1; i >= 0; i--) begin
      if (notes[i].cyc == ncyc) begin
        comparisons++;
        if (got(notes[i].kind) !== notes[i].val) begin
          fail_count++;
          $display("[FAIL] %0t kind %0d got %h want %h", $time, notes[i].kind,
                   got(notes[i].kind), notes[i].val);
        end
        notes.delete(i);
      end
    end
  end

  initial begin
    i_nrst = 1'b0;
    odd_even = 1'b1;
    offset_sel = 2'h0;
    {stall, wr_stb, rd_stb} = 6'h30;
    a_ctl = IDLE;
    b_ctl = IDLE;
    a_in = 36'h0;
    b_in = 36'h0;
    for (int s = 0; s < 4; s++)
      reset_dut(2'(s));
    af(0);
    af(1);
    mail(0);
    mail(1);
    par();
    stream(0);
    stream(1);
    repeat (6) tick();
    summarize();
  end
endmodule
